// file: pkg/dhb_pkg.sv
/*
 * Shared constants for the display host bus: section decode codes,
 * bus widths, memory sizes and timing counts on the 50 MHz system clock.
 * Assumes both ends and the bench import it whole.
 */
`default_nettype none
package dhb_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 5;
    localparam int LOC_W = 3;
    localparam int GLYPH_IDX_W = 4;
    localparam int ROW_W = 5;
    localparam int NUM_GLYPHS = 16;
    localparam int NUM_LOCS = 8;
    // section codes on the two upper address lines
    localparam logic [1:0] SEC_GLYPH_ADDR = 2'h0;
    localparam logic [1:0] SEC_GLYPH_RAM = 2'h1;
    localparam logic [1:0] SEC_CONTROL = 2'h2;
    localparam logic [1:0] SEC_CHAR_RAM = 2'h3;
    // oscillator-derived dividers
    localparam int REFRESH_DIV = 224;
    localparam int BLINK_DIV = 28672;
    localparam int SELF_TEST_PERIODS = 262144;
    localparam int ACCESS_BLACKOUT_PULSES = 3;
    // internal oscillator nominal rate, made from the system clock
    localparam int OSC_HZ = 57_000;
    localparam int OSC_DIV = CLK_HZ / OSC_HZ;
    // blackout with internal oscillator, least time rounded up
    localparam int BLACKOUT_US = 110;
    localparam int BLACKOUT_CYC = (BLACKOUT_US * (CLK_HZ / 1_000_000));
    // host strobe low time and recovery, least times rounded up
    localparam int STROBE_NS = 230;
    localparam int STROBE_CYC = (STROBE_NS + 19) / 20;
    localparam int RECOVER_NS = 60;
    localparam int RECOVER_CYC = (RECOVER_NS + 19) / 20;
    localparam int SETUP_NS = 10;
    localparam int SETUP_CYC = (SETUP_NS + 19) / 20;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
endpackage : dhb_pkg
`default_nettype wire

// file: pkg/dhb_if.sv
/*
 * Pin-level carrier between host and display. Holds the resolved
 * levels of the two-way data bus and clock pin from the enables.
 * Assumes only one side enables a driver at a time.
 */
`default_nettype none
interface dhb_if;
    import dhb_pkg::*;
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic flash_select_n;
    logic [ADDR_W-1:0] addr;
    logic rst_n;
    logic [DATA_W-1:0] host_d;
    logic host_d_oe;
    logic [DATA_W-1:0] disp_d;
    logic disp_d_oe;
    logic [DATA_W-1:0] data;
    logic clk_pin_o;
    logic clk_pin_oe;
    logic ext_clk;
    logic clk_pin;
    // resolved wire levels; an undriven bus idles high like a pullup
    assign data = disp_d_oe ? disp_d : (host_d_oe ? host_d : 8'hFF);
    assign clk_pin = clk_pin_oe ? clk_pin_o : ext_clk;
    modport host (output cs_n, output wr_n, output rd_n, output flash_select_n,
        output addr, output rst_n, output host_d, output host_d_oe, input data);
    modport display (input cs_n, input wr_n, input rd_n, input flash_select_n,
        input addr, input rst_n, output disp_d, output disp_d_oe, input data,
        output clk_pin_o, output clk_pin_oe, input clk_pin);
endinterface : dhb_if
`default_nettype wire

// file: design/dhb_display.sv
/*
 * Display end: decodes host accesses into flash, glyph address,
 * glyph RAM, control word and character RAM; makes the display clock
 * and its refresh, blink and self-test ticks.
 * Assumes pins come from another domain and are synchronised here.
 */
`default_nettype none
// Overview of operation
// - host waits three display clocks after reset
// - host frames each access with chip select
// - write only while write and select low
// - drive read data while read, select low
// - flash select low targets flash, ignores upper
// - upper address bits choose section otherwise
// - low bits pick location or glyph row
// - clock source select picks internal oscillator
// - internal clock driven out, else pin input
// - refresh, blink, self-test from oscillator divisions
// - host holds address stable under select
// - write-only host may tie read high
// - data bus two-way, display drives reads
module dhb_display
    import dhb_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_srst,
    dhb_if.display bus,
    input wire logic i_clock_source_select,
    output logic o_refresh_tick,
    output logic o_blink_tick,
    output logic o_self_test_tick,
    output logic [DATA_W-1:0] o_control_word,
    output logic [NUM_LOCS-1:0] o_flash_bits
);
    // two-flop synchronisers for every pin input
    logic [ADDR_W+5:0] pin_s1_q, pin_s2_q;
    logic [DATA_W-1:0] dat_s1_q, dat_s2_q;
    always_ff @(posedge i_sys_clk) begin
        pin_s1_q <= {bus.cs_n, bus.wr_n, bus.rd_n, bus.flash_select_n, bus.rst_n,
            bus.clk_pin, bus.addr};
        pin_s2_q <= pin_s1_q;
        dat_s1_q <= bus.data;
        dat_s2_q <= dat_s1_q;
    end
    logic cs_n, wr_n, rd_n, fl_n, rst_pin_n, clk_in;
    logic [ADDR_W-1:0] a;
    assign {cs_n, wr_n, rd_n, fl_n, rst_pin_n, clk_in, a} = pin_s2_q;
    logic rst;
    assign rst = i_srst | ~rst_pin_n;

    // memories and registers held in flip-flops
    logic [DATA_W-1:0] char_q [NUM_LOCS], char_d [NUM_LOCS];
    logic [NUM_LOCS-1:0] flash_q, flash_d;
    logic [GLYPH_IDX_W-1:0] gaddr_q, gaddr_d;
    logic [ROW_W-1:0] glyph_q [NUM_GLYPHS*NUM_LOCS], glyph_d [NUM_GLYPHS*NUM_LOCS];
    logic [DATA_W-1:0] ctrl_q, ctrl_d;
    logic wr_done_q, wr_done_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic oe_q, oe_d;
    logic [LOC_W-1:0] loc;
    logic [1:0] sec;
    logic [GLYPH_IDX_W+LOC_W-1:0] gidx;
    assign loc = a[LOC_W-1:0];
    assign sec = a[ADDR_W-1:LOC_W];
    assign gidx = {gaddr_q, loc};

    // access decode; one store per select low, so a long strobe writes once
    always_comb begin
        char_d = char_q;
        flash_d = flash_q;
        gaddr_d = gaddr_q;
        glyph_d = glyph_q;
        ctrl_d = ctrl_q;
        wr_done_d = wr_done_q & ~cs_n;
        rdata_d = DATA_RESET;
        oe_d = 1'b0;
        if (!cs_n && !wr_n && !wr_done_q) begin
            wr_done_d = 1'b1;
            if (!fl_n) begin
                flash_d[loc] = dat_s2_q[0];
            end else begin
                case (sec)
                    SEC_GLYPH_ADDR: gaddr_d = dat_s2_q[GLYPH_IDX_W-1:0];
                    SEC_GLYPH_RAM: glyph_d[gidx] = dat_s2_q[ROW_W-1:0];
                    SEC_CONTROL: ctrl_d = dat_s2_q;
                    SEC_CHAR_RAM: char_d[loc] = dat_s2_q;
                    default: ctrl_d = ctrl_q;
                endcase
            end
        end
        if (!cs_n && !rd_n && wr_n) begin
            oe_d = 1'b1;
            if (!fl_n) begin
                rdata_d = {7'h00, flash_q[loc]};
            end else begin
                case (sec)
                    SEC_GLYPH_ADDR: rdata_d = {4'h0, gaddr_q};
                    SEC_GLYPH_RAM: rdata_d = {3'h0, glyph_q[gidx]};
                    SEC_CONTROL: rdata_d = ctrl_q;
                    SEC_CHAR_RAM: rdata_d = char_q[loc];
                    default: rdata_d = DATA_RESET;
                endcase
            end
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_LOCS; i++) char_q[i] <= DATA_RESET;
            for (int i = 0; i < NUM_GLYPHS*NUM_LOCS; i++) glyph_q[i] <= '0;
            flash_q <= '0;
            gaddr_q <= '0;
            ctrl_q <= DATA_RESET;
            wr_done_q <= 1'b0;
            rdata_q <= DATA_RESET;
            oe_q <= 1'b0;
        end else begin
            char_q <= char_d;
            glyph_q <= glyph_d;
            flash_q <= flash_d;
            gaddr_q <= gaddr_d;
            ctrl_q <= ctrl_d;
            wr_done_q <= wr_done_d;
            rdata_q <= rdata_d;
            oe_q <= oe_d;
        end
    end
    // bus released whenever no read is under way
    assign bus.disp_d = rdata_q;
    assign bus.disp_d_oe = oe_q;

    // display clock: internal divider or edges of the pin clock
    logic [15:0] osc_cnt_q, osc_cnt_d;
    logic osc_lvl_q, osc_lvl_d;
    logic clk_prev_q;
    logic osc_tick;
    always_comb begin
        osc_cnt_d = osc_cnt_q + 16'h0001;
        osc_lvl_d = osc_lvl_q;
        if (osc_cnt_q == 16'(OSC_DIV / 2 - 1)) begin
            osc_cnt_d = 16'h0000;
            osc_lvl_d = ~osc_lvl_q;
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            osc_cnt_q <= 16'h0000;
            osc_lvl_q <= 1'b0;
            clk_prev_q <= 1'b0;
        end else begin
            osc_cnt_q <= osc_cnt_d;
            osc_lvl_q <= osc_lvl_d;
            clk_prev_q <= clk_in;
        end
    end
    // internal rising edge, or external rising edge from the synced pin
    assign osc_tick = i_clock_source_select ? (osc_lvl_d & ~osc_lvl_q)
        : (clk_in & ~clk_prev_q);
    // master drives its clock out so slaves share one timebase
    assign bus.clk_pin_o = osc_lvl_q;
    assign bus.clk_pin_oe = i_clock_source_select;

    // oscillator-period dividers
    logic [7:0] ref_q, ref_d;
    logic [14:0] blk_q, blk_d;
    logic [17:0] st_q, st_d;
    logic ref_t_q, blk_t_q, st_t_q;
    always_comb begin
        ref_d = ref_q;
        blk_d = blk_q;
        st_d = st_q;
        if (osc_tick) begin
            ref_d = (ref_q == 8'(REFRESH_DIV - 1)) ? 8'h00 : ref_q + 8'h01;
            blk_d = (blk_q == 15'(BLINK_DIV - 1)) ? 15'h0000 : blk_q + 15'h0001;
            st_d = (st_q == 18'(SELF_TEST_PERIODS - 1)) ? 18'h00000 : st_q + 18'h00001;
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (rst) begin
            ref_q <= 8'h00;
            blk_q <= 15'h0000;
            st_q <= 18'h00000;
            ref_t_q <= 1'b0;
            blk_t_q <= 1'b0;
            st_t_q <= 1'b0;
        end else begin
            ref_q <= ref_d;
            blk_q <= blk_d;
            st_q <= st_d;
            ref_t_q <= osc_tick && (ref_q == 8'(REFRESH_DIV - 1));
            blk_t_q <= osc_tick && (blk_q == 15'(BLINK_DIV - 1));
            st_t_q <= osc_tick && (st_q == 18'(SELF_TEST_PERIODS - 1));
        end
    end
    assign o_refresh_tick = ref_t_q;
    assign o_blink_tick = blk_t_q;
    assign o_self_test_tick = st_t_q;
    assign o_control_word = ctrl_q;
    assign o_flash_bits = flash_q;
endmodule : dhb_display
`default_nettype wire

// file: design/dhb_host.sv
/*
 * Host end: turns one user request into a framed pin-level read or
 * write, waits out the post-reset blackout, and returns read data.
 * Assumes the display synchronises its pins, so strobes are long.
 */
`default_nettype none
module dhb_host
    import dhb_pkg::*;
#(
    parameter int BLACKOUT = BLACKOUT_CYC,
    parameter int HOLD = STROBE_CYC + 4
)(
    input wire logic i_sys_clk,
    input wire logic i_srst,
    dhb_if.host bus,
    input wire logic i_req,
    input wire logic i_write,
    input wire logic i_flash,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    output logic o_ready,
    output logic o_done,
    output logic [DATA_W-1:0] o_rdata
);
    typedef enum logic [2:0] {ST_RESET, ST_WAIT, ST_IDLE, ST_SETUP, ST_STROBE,
        ST_RECOVER} dhb_state_t;
    dhb_state_t st_q, st_d;
    logic [15:0] cnt_q, cnt_d;
    logic cs_n_q, cs_n_d, wr_n_q, wr_n_d, rd_n_q, rd_n_d, fl_n_q, fl_n_d;
    logic rst_n_q, rst_n_d, oe_q, oe_d, wr_q, wr_d, done_q, done_d;
    logic ready_q, ready_d;
    logic [ADDR_W-1:0] a_q, a_d;
    logic [DATA_W-1:0] wd_q, wd_d, rd_q, rd_d;
    // sequencer: address set before select, held until select rises
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q + 16'h0001;
        cs_n_d = cs_n_q;
        wr_n_d = wr_n_q;
        rd_n_d = rd_n_q;
        fl_n_d = fl_n_q;
        rst_n_d = 1'b1;
        oe_d = oe_q;
        wr_d = wr_q;
        a_d = a_q;
        wd_d = wd_q;
        rd_d = rd_q;
        done_d = 1'b0;
        case (st_q)
            ST_RESET: begin
                rst_n_d = 1'b0;
                if (cnt_q == 16'(STROBE_CYC + 16)) begin
                    st_d = ST_WAIT;
                    cnt_d = 16'h0000;
                end
            end
            ST_WAIT: if (cnt_q == 16'(BLACKOUT - 1)) st_d = ST_IDLE;
            ST_IDLE: if (i_req) begin
                a_d = i_addr;
                fl_n_d = ~i_flash;
                wd_d = i_wdata;
                wr_d = i_write;
                oe_d = i_write;
                cnt_d = 16'h0000;
                st_d = ST_SETUP;
            end
            ST_SETUP: if (cnt_q == 16'(SETUP_CYC + 2)) begin
                cs_n_d = 1'b0;
                wr_n_d = ~wr_q;
                rd_n_d = wr_q;
                cnt_d = 16'h0000;
                st_d = ST_STROBE;
            end
            ST_STROBE: if (cnt_q == 16'(HOLD - 1)) begin
                rd_d = bus.data;
                cs_n_d = 1'b1;
                wr_n_d = 1'b1;
                rd_n_d = 1'b1;
                cnt_d = 16'h0000;
                st_d = ST_RECOVER;
            end
            ST_RECOVER: if (cnt_q == 16'(RECOVER_CYC + 4)) begin
                oe_d = 1'b0;
                done_d = 1'b1;
                st_d = ST_IDLE;
            end
            default: st_d = ST_RESET;
        endcase
        // registered so the user sees ready straight from a flop
        ready_d = (st_d == ST_IDLE);
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            st_q <= ST_RESET;
            cnt_q <= 16'h0000;
            cs_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            fl_n_q <= 1'b1;
            rst_n_q <= 1'b0;
            oe_q <= 1'b0;
            wr_q <= 1'b0;
            a_q <= '0;
            wd_q <= DATA_RESET;
            rd_q <= DATA_RESET;
            done_q <= 1'b0;
            ready_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            cs_n_q <= cs_n_d;
            wr_n_q <= wr_n_d;
            rd_n_q <= rd_n_d;
            fl_n_q <= fl_n_d;
            rst_n_q <= rst_n_d;
            oe_q <= oe_d;
            wr_q <= wr_d;
            a_q <= a_d;
            wd_q <= wd_d;
            rd_q <= rd_d;
            done_q <= done_d;
            ready_q <= ready_d;
        end
    end
    assign bus.cs_n = cs_n_q;
    assign bus.wr_n = wr_n_q;
    assign bus.rd_n = rd_n_q;
    assign bus.flash_select_n = fl_n_q;
    assign bus.addr = a_q;
    assign bus.rst_n = rst_n_q;
    assign bus.host_d = wd_q;
    assign bus.host_d_oe = oe_q;
    assign o_ready = ready_q;
    assign o_done = done_q;
    assign o_rdata = rd_q;
endmodule : dhb_host
`default_nettype wire

// file: tb/dhb_bus_sva.sv
/*
 * Pin-level checks on the host/display interface signals.
 * Assumes one system clock and a synchronous active-high reset.
 */
`default_nettype none
module dhb_bus_sva
    import dhb_pkg::*;
#(
    parameter int MIN_GAP = 24
)(
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic i_clock_source_select,
    input wire logic cs_n,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic flash_select_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic rst_n,
    input wire logic host_d_oe,
    input wire logic disp_d_oe,
    input wire logic clk_pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] since_rst_q;
    logic [15:0] since_rst_d;
    // cycles since the display reset line rose; saturates so it never wraps back
    always_comb begin
        since_rst_d = since_rst_q;
        if (!rst_n) begin
            since_rst_d = 16'h0000;
        end else if (since_rst_q != 16'hFFFF) begin
            since_rst_d = since_rst_q + 16'h0001;
        end
    end
    always_ff @(posedge i_sys_clk) begin
        since_rst_q <= i_srst ? 16'h0000 : since_rst_d;
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    // host side framing and blackout
    property p_blackout;
        $fell(cs_n) |-> int'(since_rst_q) >= MIN_GAP;
    endproperty
    a_blackout: assert property (p_blackout)
        else $error("select fell inside reset blackout");
    property p_recover;
        $rose(cs_n) |-> cs_n [*3];
    endproperty
    a_recover: assert property (p_recover)
        else $error("select high too briefly between cycles");
    property p_strobe_in_select;
        (!wr_n || !rd_n) |-> !cs_n;
    endproperty
    a_strobe_in_select: assert property (p_strobe_in_select)
        else $error("strobe low without select");
    property p_addr_hold;
        !cs_n |=> cs_n || ($stable(addr) && $stable(flash_select_n));
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("address moved under select");
    // data bus ownership
    property p_write_drives;
        (!cs_n && !wr_n) |-> host_d_oe && rd_n && !disp_d_oe;
    endproperty
    a_write_drives: assert property (p_write_drives)
        else $error("write without host owning the bus");
    property p_read_cause;
        $rose(disp_d_oe) |-> !cs_n && !rd_n && wr_n;
    endproperty
    a_read_cause: assert property (p_read_cause)
        else $error("display drove bus outside a read");
    property p_read_answer;
        $fell(rd_n) |-> ##[1:8] disp_d_oe;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("display did not answer a read");
    property p_release;
        (cs_n || rd_n) [*6] |-> !disp_d_oe;
    endproperty
    a_release: assert property (p_release)
        else $error("display kept the bus after the read");
    property p_no_fight;
        disp_d_oe |-> !host_d_oe;
    endproperty
    a_no_fight: assert property (p_no_fight)
        else $error("both ends drive the data bus");
    // clock pin direction follows the source select
    property p_clk_pin;
        $stable(i_clock_source_select) |-> clk_pin_oe == i_clock_source_select;
    endproperty
    a_clk_pin: assert property (p_clk_pin)
        else $error("clock pin direction wrong for source");
endmodule : dhb_bus_sva
`default_nettype wire

// file: tb/display_host_bus_decoder_tb.sv
/*
 * Bench joining host and display ends; drives user requests, checks memories.
 * Assumes the package and interface are compiled first.
 */
`default_nettype none
module display_host_bus_decoder_tb;
    import dhb_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BLK = 50;
    localparam int EXT_PER = 2; // display clock period in system clocks; short to reach a blink
    logic i_sys_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_clock_source_select = 1'b0;
    logic i_req = 1'b0;
    logic i_write = 1'b0;
    logic i_flash = 1'b0;
    logic [ADDR_W-1:0] i_addr = '0;
    logic [DATA_W-1:0] i_wdata = '0;
    logic o_ready, o_done, o_refresh_tick, o_blink_tick, o_self_test_tick, prev;
    logic [DATA_W-1:0] o_rdata, o_control_word, rd;
    logic [NUM_LOCS-1:0] o_flash_bits;
    int err_count = 0;
    int check_count = 0;
    int n;
    int ref_seen = 0;
    int st_seen = 0;
    dhb_if bus ();
    // tick tallies at the falling edge, where the registered pulses are settled
    always @(negedge i_sys_clk) begin
        if (o_refresh_tick === 1'b1) begin
            ref_seen++;
        end
        if (o_self_test_tick === 1'b1) begin
            st_seen++;
        end
    end
    always #10 i_sys_clk = ~i_sys_clk;
    // external display clock, phase unrelated to the system clock
    initial begin
        bus.ext_clk = 1'b0;
        #7;
        forever #(EXT_PER * 10) bus.ext_clk = ~bus.ext_clk;
    end
    dhb_host #(.BLACKOUT(BLK)) dhb_host_i (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
        .bus(bus), .i_req(i_req), .i_write(i_write), .i_flash(i_flash), .i_addr(i_addr),
        .i_wdata(i_wdata), .o_ready(o_ready), .o_done(o_done), .o_rdata(o_rdata));
    dhb_display dhb_display_i (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .bus(bus),
        .i_clock_source_select(i_clock_source_select), .o_refresh_tick(o_refresh_tick),
        .o_blink_tick(o_blink_tick), .o_self_test_tick(o_self_test_tick),
        .o_control_word(o_control_word), .o_flash_bits(o_flash_bits));
    dhb_bus_sva #(.MIN_GAP(3 * EXT_PER)) dhb_bus_sva_i (.i_sys_clk(i_sys_clk),
        .i_srst(i_srst), .i_clock_source_select(i_clock_source_select), .cs_n(bus.cs_n),
        .wr_n(bus.wr_n), .rd_n(bus.rd_n), .flash_select_n(bus.flash_select_n),
        .addr(bus.addr), .rst_n(bus.rst_n), .host_d_oe(bus.host_d_oe),
        .disp_d_oe(bus.disp_d_oe), .clk_pin_oe(bus.clk_pin_oe));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            err_count++;
            $display("MISMATCH %s expected %0h seen %0h", what, want, seen);
        end
    endtask : check
    // one framed access; called and left on a falling edge so requests chain back to back
    task automatic xfer(input logic wr, input logic fl, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d);
        n = 0;
        while (o_ready !== 1'b1 && n < 500) begin
            @(negedge i_sys_clk);
            n++;
        end
        i_req = 1'b1;
        i_write = wr;
        i_flash = fl;
        i_addr = a;
        i_wdata = d;
        @(negedge i_sys_clk);
        i_req = 1'b0;
        n = 0;
        while (o_done !== 1'b1 && n < 500) begin
            @(negedge i_sys_clk);
            n++;
        end
        if (n >= 500) begin
            err_count++;
            $display("MISMATCH done expected pulse seen none");
        end
        rd = o_rdata;
    endtask : xfer
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test
    // watchdog: the blink wait dominates, about sixty thousand cycles in all
    initial begin
        repeat (70000) @(posedge i_sys_clk);
        err_count++;
        $display("MISMATCH watchdog expected finish seen timeout");
        end_of_test();
    end
    // main sequence
    initial begin
        repeat (12) @(negedge i_sys_clk);
        i_srst = 1'b0;
        check("control reset", o_control_word, DATA_RESET);
        xfer(1'b1, 1'b0, {SEC_CONTROL, 3'h5}, 8'h5A);
        check("control word", o_control_word, 8'h5A);
        xfer(1'b0, 1'b0, {SEC_CONTROL, 3'h2}, 8'h00);
        check("control read", rd, 8'h5A);
        for (int i = 0; i < NUM_LOCS; i++) begin
            xfer(1'b1, 1'b0, {SEC_CHAR_RAM, 3'(i)}, 8'h41 + 8'(i));
        end
        // flash writes with upper address lines scattered; only data bit 0 counts
        for (int i = 0; i < NUM_LOCS; i++) begin
            xfer(1'b1, 1'b1, {2'(i), 3'(i)}, 8'hA4 | 8'(i % 2));
        end
        check("flash bits", o_flash_bits, 8'hAA);
        xfer(1'b0, 1'b1, {2'h3, 3'h1}, 8'h00);
        check("flash read", 32'(rd[0]), 32'h1);
        for (int i = 0; i < NUM_LOCS; i++) begin
            xfer(1'b0, 1'b0, {SEC_CHAR_RAM, 3'(i)}, 8'h00);
            check("char ram", rd, 8'h41 + 8'(i));
        end
        // glyph rows under index 3, then a row under index 4 must not alias
        xfer(1'b1, 1'b0, {SEC_GLYPH_ADDR, 3'h6}, 8'h03);
        for (int r = 0; r < 7; r++) begin
            xfer(1'b1, 1'b0, {SEC_GLYPH_RAM, 3'(r)}, 8'hF0 + 8'(r));
        end
        xfer(1'b1, 1'b0, {SEC_GLYPH_ADDR, 3'h1}, 8'h04);
        xfer(1'b1, 1'b0, {SEC_GLYPH_RAM, 3'h0}, 8'h0F);
        xfer(1'b1, 1'b0, {SEC_GLYPH_ADDR, 3'h2}, 8'h03);
        xfer(1'b0, 1'b0, {SEC_GLYPH_ADDR, 3'h7}, 8'h00);
        check("glyph index", rd & 8'h0F, 8'h03);
        for (int r = 0; r < 7; r++) begin
            xfer(1'b0, 1'b0, {SEC_GLYPH_RAM, 3'(r)}, 8'h00);
            check("glyph row", rd & 8'h1F, 8'h10 + 8'(r));
        end
        // refresh spacing in system clocks, measured between two ticks
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(negedge i_sys_clk);
                n++;
            end while (o_refresh_tick !== 1'b1 && n < 5000);
        end
        check("refresh gap", n, REFRESH_DIV * EXT_PER);
        // both dividers start at the display reset, so the first blink lands on a refresh
        n = 0;
        while (o_blink_tick !== 1'b1 && n < 60000) begin
            @(negedge i_sys_clk);
            n++;
        end
        check("refresh with blink", o_refresh_tick, 1'b1);
        @(negedge i_sys_clk);
        check("refreshes per blink", ref_seen, BLINK_DIV / REFRESH_DIV);
        check("self-test early", st_seen, 0);
        check("clock pin input", bus.clk_pin_oe, 1'b0);
        // switched last: changing source mid-run may disturb the dividers
        i_clock_source_select = 1'b1;
        repeat (4) @(negedge i_sys_clk);
        check("clock pin output", bus.clk_pin_oe, 1'b1);
        prev = bus.clk_pin;
        n = 0;
        for (int k = 0; k < 1000; k++) begin
            @(negedge i_sys_clk);
            if (bus.clk_pin !== prev) begin
                n++;
            end
            prev = bus.clk_pin;
        end
        check("osc toggles", 32'(n == 2 || n == 3), 32'h1);
        end_of_test();
    end
endmodule : display_host_bus_decoder_tb
`default_nettype wire
